//--- bench/output_pin_and_blank_config_tb_top.sv
`timescale 1ns/1ps
module output_pin_and_blank_config_tb_top;
   import pin_mux_pkg::*;
   logic sys_clk_in, rst_in, wr, rd, rvalid, msy_i, csy_i, fld_i, fsy_i, pin_one, pin_two, fly;
   logic msy_o, csy_o, sync_oe_n, res_en, b_one, b_two, b_any, b_win2, mon, clamp, full_line_measure_window;
   logic fly_act, hc;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, q;
   logic [4:0] colour;
   logic [2:0] strength;
   logic [6:0] gp_in, gp_out, gp_oe_n;
   logic [7:0] ofs [4] = '{8'h10, 8'h31, 8'h32, 8'h34};
   logic [15:0] msk [4] = '{16'h00e7, 16'h007f, 16'h009f, 16'hffff};
   int fails = 0;
   int n_compared = 0;
   int n;

   output_pin_and_blank_config u_output_pin_and_blank_config
   (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .main_sync_in(msy_i), .composite_sync_in(csy_i), .field_in(fld_i),
      .front_sync_in(fsy_i), .colour_in(colour),
      .main_sync_pin_out(msy_o), .composite_sync_pin_out(csy_o), .sync_oe_n_out(sync_oe_n),
      .sync_drive_strength_out(strength), .deflection_resistor_enable_out(res_en),
      .blank_input_pin_one_in(pin_one), .blank_input_pin_two_in(pin_two), .flyback_in(fly),
      .blank_one_out(b_one), .blank_two_out(b_two), .blank_any_out(b_any),
      .blank_from_two_out(b_win2), .monitor_input_select_out(mon),
      .rgb_clamp_reference_enable_out(clamp), .full_line_measure_window_out(full_line_measure_window),
      .flyback_active_out(fly_act), .half_contrast_out(hc),
      .general_pin_in(gp_in), .general_pin_out(gp_out), .general_pin_oe_n_out(gp_oe_n)
   );

   reg_host u_reg_host
   (
      .sys_clk_in(sys_clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
      .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid)
   );

   // ************************************
   // clock, checking and closing
   // ************************************
   initial
   begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude;
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // async pins need three edges, register bits two after the strobe
   task automatic settle;
      repeat (5) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic blank_case(input logic [7:0] m1, input logic [7:0] m2, input logic p1,
      input logic p2, input logic [2:0] e);
      u_reg_host.wr(8'h32, {8'h00, m1});
      u_reg_host.wr(8'h31, {8'h00, m2});
      pin_one = p1;
      pin_two = p2;
      settle();
      chk("blank", {12'h000, b_any, b_one, b_two, b_win2}, {12'h000, e[2] | e[1], e});
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      fails++;
      conclude();
   end

   // ************************************
   // tests
   // ************************************
   initial
   begin
      rst_in = 1'b1;
      {msy_i, csy_i, fld_i, fsy_i, pin_one, pin_two, fly} = 7'h00;
      colour = 5'h00;
      gp_in = 7'h00;
      repeat (12) @(posedge sys_clk_in);
      #1;
      rst_in = 1'b0;
      chk("reset pins", {8'h00, sync_oe_n, gp_oe_n}, 16'h0003);
      foreach (ofs[i])
      begin
         u_reg_host.rd(ofs[i], q);
         chk("reset value", q, 16'h0000);
         u_reg_host.wr(ofs[i], 16'hffff);
         u_reg_host.rd(ofs[i], q);
         chk("writable bits", q, msk[i]);
         u_reg_host.wr(ofs[i], 16'h0000);
      end
      u_reg_host.wr(8'h33, 16'hffff);
      u_reg_host.rd(8'h33, q);
      chk("unmapped", q, 16'h0000);
      for (int s = 0; s < 8; s++)
      begin
         u_reg_host.wr(8'h10, 16'(s));
         settle();
         chk("strength", {12'h000, sync_oe_n, strength}, {12'h000, s == 7, 3'(s)});
      end
      msy_i = 1'b1;
      u_reg_host.wr(8'h10, 16'h0020);
      settle();
      chk("resistor", 16'(res_en), 16'h0001);
      chk("main sync", 16'(msy_o), 16'h0001);
      for (int v = 0; v < 2; v++)
      begin
         csy_i = v[0];
         fld_i = ~v[0];
         for (int c = 0; c < 3; c++)
         begin
            u_reg_host.wr(8'h10, 16'(c << 6));
            settle();
            chk("sync pin fn", 16'(csy_o), {15'h0000, c == 0 ? v[0] : c == 1 ? ~v[0] : 1'b0});
         end
      end
      u_reg_host.wr(8'h10, 16'h00c0);
      // let the function switch pass so only drive clock toggles are timed
      settle();
      q[0] = csy_o;
      for (n = 0; n < 250 && csy_o === q[0]; n++)
      begin
         @(posedge sys_clk_in);
         #1;
      end
      q[0] = csy_o;
      for (n = 0; n < 250 && csy_o === q[0]; n++)
      begin
         @(posedge sys_clk_in);
         #1;
      end
      chk("drive clock half", 16'(n), 16'd100);
      blank_case(8'h00, 8'h00, 1'b1, 1'b0, 3'b100);
      blank_case(8'h01, 8'h00, 1'b0, 1'b0, 3'b100);
      blank_case(8'h80, 8'h00, 1'b1, 1'b0, 3'b000);
      blank_case(8'h04, 8'h00, 1'b0, 1'b0, 3'b110);
      blank_case(8'h00, 8'h01, 1'b0, 1'b0, 3'b011);
      blank_case(8'h00, 8'h02, 1'b0, 1'b1, 3'b000);
      blank_case(8'h00, 8'h04, 1'b1, 1'b1, 3'b111);
      blank_case(8'h00, 8'h00, 1'b1, 1'b1, 3'b110);
      u_reg_host.wr(8'h32, 16'h001a);
      settle();
      chk("fly clamp window", {13'h0, fly_act, clamp, full_line_measure_window}, 16'h0007);
      u_reg_host.wr(8'h32, 16'h0000);
      fly = 1'b1;
      u_reg_host.wr(8'h31, 16'h0008);
      settle();
      chk("fly clamp window", {13'h0, fly_act, clamp, full_line_measure_window}, 16'h0004);
      chk("monitor", 16'(mon), 16'h0001);
      gp_in = 7'h01;
      u_reg_host.wr(8'h34, 16'h8101);
      foreach (msk[i])
      begin
         u_reg_host.wr(8'h31, {8'h00, 8'h10 * i[7:0] + (i == 3 ? 8'h20 : 8'h00)});
         settle();
         chk("half contrast", 16'(hc), 16'(i == 1 || i == 2));
         chk("pin zero share", 16'(gp_oe_n[0]), 16'(i == 1 || i == 3));
      end
      u_reg_host.wr(8'h31, 16'h0000);
      gp_in = 7'h2a;
      u_reg_host.wr(8'h34, 16'h8f55);
      settle();
      u_reg_host.rd(8'h34, q);
      chk("port readback", q, 16'h8f25);
      chk("port drive", {5'h00, gp_oe_n, gp_out[3:0]}, {5'h00, 7'h70, 4'h5});
      fsy_i = 1'b1;
      u_reg_host.wr(8'h34, 16'h8080);
      settle();
      chk("front sync on", {8'h00, gp_out[1], gp_oe_n}, 16'h00fd);
      fsy_i = 1'b0;
      settle();
      chk("front sync off", 16'(gp_out[1]), 16'h0000);
      colour = 5'h15;
      u_reg_host.wr(8'h34, 16'h0000);
      settle();
      chk("colour share", {4'h0, gp_oe_n, gp_out[6:2]}, {4'h0, 7'h03, 5'h15});
      u_reg_host.wr(8'h34, 16'h8000);
      settle();
      chk("port share", {9'h000, gp_oe_n}, 16'h007f);
      conclude();
   end
endmodule

//--- bench/reg_host.sv
`timescale 1ns/1ps
// ************************************
// host model of the sub-address register port
// ************************************
module reg_host
(
   // clock
   input wire logic sys_clk_in,
   // register port
   output logic [7:0] reg_addr_out,
   output logic [15:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [15:0] reg_rdata_in,
   input wire logic reg_rvalid_in
);
   initial
   begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 16'h0000;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end

   // the whole word goes in one strobe; each call first lets an edge pass
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      #1;
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(posedge sys_clk_in);
      #1;
      reg_wr_out = 1'b0;
      // idle data lines change so a stale word can never be taken twice
      reg_wdata_out = ~d;
   endtask

   // answer is looked for in the cycles after the read edge, bounded
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      int n;
      @(posedge sys_clk_in);
      #1;
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(posedge sys_clk_in);
      #1;
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      q = 16'hxxxx;
      for (n = 0; n < 4 && reg_rvalid_in !== 1'b1; n++)
      begin
         @(posedge sys_clk_in);
         #1;
      end
      if (reg_rvalid_in === 1'b1)
         q = reg_rdata_in;
   endtask
endmodule

//--- design/blank_source.sv
`timescale 1ns/1ps
// turns a pin level into an internal active-high signal with force controls
module blank_source
(
   // pin level and its polarity
   input wire logic pin_in,
   input wire logic invert_in,
   // forcing controls
   input wire logic force_high_in,
   input wire logic force_low_in,
   // internal signal
   output logic level_out
);
   // force high wins when software sets both forces
   always_comb
   begin
      if (force_high_in)
         level_out = 1'b1;
      else if (force_low_in)
         level_out = 1'b0;
      else
         level_out = pin_in ^ invert_in;
   end
endmodule

//--- design/output_pin_and_blank_config.sv
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
//
// Contract
// - sync drive: 7 tristate, 6 weakest, 0 strongest
// - bit connects deflection output internal resistor
// - force-high bit forces first blank high
// - force-low bit forces first blank low
// - polarity bit makes fast blank active low
// - bit enables rgb clamping reference
// - bit selects full-line measurement window
// - polarity bit inverts horizontal flyback input
// - second blank follows pin unless forced
// - priority bit picks which blank input wins
// - monitor-select bit names monitor's blank input
// - share bit gives pin zero to half contrast
// - force bit drives half contrast high
// - polarity bit makes half contrast pin active-low
// - seven port bits carry pin data
// - bit drives front sync on port pin one
// - direction bits: clear input, set output
// - share bit swaps colour outputs and pins 2-6
//
module output_pin_and_blank_config
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // register port by sub-address
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // internal sync and colour sources
   input wire logic main_sync_in,
   input wire logic composite_sync_in,
   input wire logic field_in,
   input wire logic front_sync_in,
   input wire logic [4:0] colour_in,
   // sync pins
   output logic main_sync_pin_out,
   output logic composite_sync_pin_out,
   output logic sync_oe_n_out,
   output logic [2:0] sync_drive_strength_out,
   output logic deflection_resistor_enable_out,
   // fast blank and flyback pins
   input wire logic blank_input_pin_one_in,
   input wire logic blank_input_pin_two_in,
   input wire logic flyback_in,
   // internal blanking and control signals
   output logic blank_one_out,
   output logic blank_two_out,
   output logic blank_any_out,
   output logic blank_from_two_out,
   output logic monitor_input_select_out,
   output logic rgb_clamp_reference_enable_out,
   output logic full_line_measure_window_out,
   output logic flyback_active_out,
   output logic half_contrast_out,
   // general port pins, pin zero shared with half contrast
   input wire logic [6:0] general_pin_in,
   output logic [6:0] general_pin_out,
   output logic [6:0] general_pin_oe_n_out
);
   import pin_mux_pkg::*;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [6:0] gp_s;
   logic fb1_s;
   logic fb2_s;
   logic fly_s;
   logic fb1_lvl;
   logic fb2_lvl;
   logic hc_lvl;
   logic hc_pin;
   pin_mux_state_s st_r;
   pin_mux_state_s st_nxt;
   sync_pin_function_e csy_func;

   sync_pair #(.W(10)) u_sync
   (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .d_in({flyback_in, blank_input_pin_two_in, blank_input_pin_one_in, general_pin_in}),
      .q_out({fly_s, fb2_s, fb1_s, gp_s})
   );

   // ****************************************
   // blank and half contrast sources
   // ****************************************
   blank_source u_fb1
   (
      .pin_in(fb1_s),
      .invert_in(st_r.blank1[`B_FB_POL]),
      .force_high_in(st_r.blank1[`B_FB1_FH]),
      .force_low_in(st_r.blank1[`B_FB1_FL]),
      .level_out(fb1_lvl)
   );

   blank_source u_fb2
   (
      .pin_in(fb2_s),
      .invert_in(st_r.blank1[`B_FB_POL]),
      .force_high_in(st_r.blank2[`B_FB2_FH]),
      .force_low_in(st_r.blank2[`B_FB2_FL]),
      .level_out(fb2_lvl)
   );

   // the pin only reaches half contrast while it is handed over from the port
   assign hc_pin = gp_s[0] & st_r.blank2[`B_HC_SHARE];

   blank_source u_hc
   (
      .pin_in(hc_pin),
      .invert_in(st_r.blank2[`B_HC_POL] & st_r.blank2[`B_HC_SHARE]),
      .force_high_in(st_r.blank2[`B_HC_FH]),
      .force_low_in(1'b0),
      .level_out(hc_lvl)
   );

   assign csy_func = sync_pin_function_e'(st_r.out_cfg[`B_CSY_HI:`B_CSY_LO]);

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      // register writes; reserved bits are held at zero
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            `OFS_OUT_CFG: st_nxt.out_cfg = reg_wdata_in[7:0] & `MSK_OUT_CFG;
            `OFS_BLANK2: st_nxt.blank2 = reg_wdata_in[7:0] & `MSK_BLANK2;
            `OFS_BLANK1: st_nxt.blank1 = reg_wdata_in[7:0] & `MSK_BLANK1;
            `OFS_GIO: st_nxt.gio = reg_wdata_in;
            default: st_nxt.gio = st_r.gio;
         endcase
      end
      // register reads answer one cycle later; unknown sub-addresses read zero
      if (reg_rd_in)
      begin
         st_nxt.rvalid = 1'b1;
         case (reg_addr_in)
            `OFS_OUT_CFG: st_nxt.rdata = {8'h00, st_r.out_cfg};
            `OFS_BLANK2: st_nxt.rdata = {8'h00, st_r.blank2};
            `OFS_BLANK1: st_nxt.rdata = {8'h00, st_r.blank1};
            `OFS_GIO:
            begin
               st_nxt.rdata = st_r.gio;
               for (int i = 0; i < 7; i++)
               begin
                  if (!st_r.gio[`B_DIR_LO + i])
                     st_nxt.rdata[i] = gp_s[i];
               end
            end
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
      // 1 MHz horizontal drive clock from a divide-by-200
      if (st_r.hdiv == 7'(`HCLK_HALF_CYC - 1))
      begin
         st_nxt.hdiv = 7'h00;
         st_nxt.hclk = !st_r.hclk;
      end
      else
         st_nxt.hdiv = st_r.hdiv + 7'h01;
      // sync pins
      st_nxt.strength = st_r.out_cfg[`B_STR_HI:`B_STR_LO];
      st_nxt.sync_oe_n = (st_r.out_cfg[`B_STR_HI:`B_STR_LO] == `STR_TRISTATE);
      st_nxt.res_en = st_r.out_cfg[`B_RES_EN];
      st_nxt.main_sync = main_sync_in;
      case (csy_func)
         CSY_COMPOSITE: st_nxt.csync = composite_sync_in;
         CSY_FIELD: st_nxt.csync = field_in;
         CSY_LOW: st_nxt.csync = 1'b0;
         CSY_HCLK: st_nxt.csync = st_r.hclk;
         default: st_nxt.csync = 1'b0;
      endcase
      // blanking
      st_nxt.blank_one = fb1_lvl;
      st_nxt.blank_two = fb2_lvl;
      st_nxt.blank_any = fb1_lvl | fb2_lvl;
      if (st_r.blank2[`B_PRIO])
         st_nxt.blank_from_two = fb2_lvl;
      else
         st_nxt.blank_from_two = fb2_lvl & !fb1_lvl;
      st_nxt.mon_two = st_r.blank2[`B_MON];
      st_nxt.clamp_en = st_r.blank1[`B_CLAMP];
      st_nxt.full_line_measure_window = st_r.blank1[`B_FULL_LINE_MEASURE_WINDOW];
      st_nxt.flyback = fly_s ^ st_r.blank1[`B_FLY_POL];
      st_nxt.half_contrast = hc_lvl;
      // general port pins
      for (int i = 0; i < 7; i++)
      begin
         st_nxt.gp_o[i] = st_r.gio[`B_DATA_LO + i];
         st_nxt.gp_oe_n[i] = !st_r.gio[`B_DIR_LO + i];
      end
      if (st_r.blank2[`B_HC_SHARE])
      begin
         st_nxt.gp_o[0] = 1'b0;
         st_nxt.gp_oe_n[0] = 1'b1;
      end
      if (st_r.gio[`B_FSY_OE])
      begin
         st_nxt.gp_o[1] = front_sync_in;
         st_nxt.gp_oe_n[1] = 1'b0;
      end
      // colour outputs own pins 2 to 6 until the port takes them over
      if (!st_r.gio[`B_SHARE])
      begin
         st_nxt.gp_o[6:2] = colour_in;
         st_nxt.gp_oe_n[6:2] = 5'h00;
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         st_r <= '0;
         st_r.out_cfg <= `RST_OUT_CFG;
         st_r.blank2 <= `RST_BLANK2;
         st_r.blank1 <= `RST_BLANK1;
         st_r.gio <= `RST_GIO;
         // pins 0 and 1 start as inputs; colour outputs drive 2 to 6
         st_r.gp_oe_n <= 7'h03;
      end
      else
         st_r <= st_nxt;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata_out = st_r.rdata;
   assign reg_rvalid_out = st_r.rvalid;
   assign main_sync_pin_out = st_r.main_sync;
   assign composite_sync_pin_out = st_r.csync;
   assign sync_oe_n_out = st_r.sync_oe_n;
   assign sync_drive_strength_out = st_r.strength;
   assign deflection_resistor_enable_out = st_r.res_en;
   assign blank_one_out = st_r.blank_one;
   assign blank_two_out = st_r.blank_two;
   assign blank_any_out = st_r.blank_any;
   assign blank_from_two_out = st_r.blank_from_two;
   assign monitor_input_select_out = st_r.mon_two;
   assign rgb_clamp_reference_enable_out = st_r.clamp_en;
   assign full_line_measure_window_out = st_r.full_line_measure_window;
   assign flyback_active_out = st_r.flyback;
   assign half_contrast_out = st_r.half_contrast;
   assign general_pin_out = st_r.gp_o;
   assign general_pin_oe_n_out = st_r.gp_oe_n;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_write_out_cfg(logic [2:0] v);
      reg_wr_in && reg_addr_in == `OFS_OUT_CFG && reg_wdata_in[2:0] == v;
   endsequence

   sequence s_read_gio;
      reg_rd_in && !reg_wr_in && reg_addr_in == `OFS_GIO;
   endsequence

   a_sync_tristate: assert property (
      s_write_out_cfg(`STR_TRISTATE) |=> ##1 sync_oe_n_out && sync_drive_strength_out == 3'h7)
      else $error("sync pins not tristated by strength 7");

   a_sync_weakest: assert property (
      s_write_out_cfg(`STR_WEAKEST) |=> ##1 !sync_oe_n_out && sync_drive_strength_out == 3'h6)
      else $error("weakest strength not applied");

   a_resistor_follows: assert property (
      ##1 deflection_resistor_enable_out == $past(st_r.out_cfg[`B_RES_EN]))
      else $error("resistor enable does not follow its bit");

   a_csync_low: assert property (
      csy_func == CSY_LOW |=> !composite_sync_pin_out)
      else $error("composite sync pin not low in code 10");

   a_blank_force_high: assert property (
      st_r.blank1[`B_FB1_FH] |=> blank_one_out && blank_any_out)
      else $error("first blank not forced high");

   a_blank_force_low: assert property (
      st_r.blank1[`B_FB1_FL] && !st_r.blank1[`B_FB1_FH] |=> !blank_one_out)
      else $error("first blank not forced low");

   a_blank_priority: assert property (
      fb1_lvl && fb2_lvl |=> blank_from_two_out == $past(st_r.blank2[`B_PRIO]))
      else $error("wrong blank input won priority");

   a_flyback_polarity: assert property (
      ##1 flyback_active_out == ($past(fly_s) ^ $past(st_r.blank1[`B_FLY_POL])))
      else $error("flyback polarity wrong");

   a_front_sync_pin: assert property (
      st_r.gio[`B_FSY_OE] |=> !general_pin_oe_n_out[1] && general_pin_out[1] == $past(front_sync_in))
      else $error("front sync not driven on pin one");

   a_colour_share: assert property (
      !st_r.gio[`B_SHARE] |=> general_pin_oe_n_out[6:2] == 5'h00 && general_pin_out[6:2] == $past(colour_in))
      else $error("colour outputs not on pins 2 to 6");

   a_read_answer: assert property (
      s_read_gio |=> reg_rvalid_out && reg_rdata_out[15:7] == $past(st_r.gio[15:7]))
      else $error("port register read answer wrong");
endmodule

//--- design/output_pin_and_blank_config_unused_placeholder_none.sv
`timescale 1ns/1ps

//--- design/pin_mux_cfg.svh
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// ****************************************
// sub-addresses
// ****************************************
`define OFS_OUT_CFG 8'h10
`define OFS_BLANK2 8'h31
`define OFS_BLANK1 8'h32
`define OFS_GIO 8'h34

// ****************************************
// reset values and writable-bit masks
// ****************************************
`define RST_OUT_CFG 8'h00
`define RST_BLANK2 8'h00
`define RST_BLANK1 8'h00
`define RST_GIO 16'h0000
`define MSK_OUT_CFG 8'he7
`define MSK_BLANK2 8'h7f
`define MSK_BLANK1 8'h9f

// ****************************************
// output pin configuration fields
// ****************************************
`define B_STR_LO 0
`define B_STR_HI 2
`define STR_TRISTATE 3'h7
`define STR_WEAKEST 3'h6
`define B_RES_EN 5
`define B_CSY_LO 6
`define B_CSY_HI 7

// ****************************************
// first blank mode fields
// ****************************************
`define B_FB1_FH 0
`define B_FULL_LINE_MEASURE_WINDOW 1
`define B_FB_POL 2
`define B_CLAMP 3
`define B_FLY_POL 4
`define B_FB1_FL 7

// ****************************************
// second blank mode fields
// ****************************************
`define B_FB2_FH 0
`define B_FB2_FL 1
`define B_PRIO 2
`define B_MON 3
`define B_HC_SHARE 4
`define B_HC_FH 5
`define B_HC_POL 6

// ****************************************
// general port fields
// ****************************************
`define B_DATA_LO 0
`define B_DATA_HI 6
`define B_FSY_OE 7
`define B_DIR_LO 8
`define B_DIR_HI 14
`define B_SHARE 15

// ****************************************
// horizontal drive clock timing
// ****************************************
`define CLK_PERIOD_PS 5000
`define HCLK_PERIOD_NS 1000
`define HCLK_HALF_CYC ((`HCLK_PERIOD_NS * 1000) / `CLK_PERIOD_PS / 2)

`endif

//--- design/pin_mux_pkg.sv
package pin_mux_pkg;
   `include "pin_mux_cfg.svh"

   typedef enum logic [1:0]
   {
      CSY_COMPOSITE = 2'b00,
      CSY_FIELD = 2'b01,
      CSY_LOW = 2'b10,
      CSY_HCLK = 2'b11
   } sync_pin_function_e;

   typedef struct packed
   {
      logic [7:0] out_cfg;
      logic [7:0] blank2;
      logic [7:0] blank1;
      logic [15:0] gio;
      logic [15:0] rdata;
      logic rvalid;
      logic [6:0] hdiv;
      logic hclk;
      logic main_sync;
      logic csync;
      logic sync_oe_n;
      logic [2:0] strength;
      logic res_en;
      logic blank_one;
      logic blank_two;
      logic blank_any;
      logic blank_from_two;
      logic mon_two;
      logic clamp_en;
      logic full_line_measure_window;
      logic flyback;
      logic half_contrast;
      logic [6:0] gp_o;
      logic [6:0] gp_oe_n;
   } pin_mux_state_s;
endpackage

//--- design/sync_pair.sv
`timescale 1ns/1ps
// two-stage synchroniser for pins that arrive from outside the clock domain
module sync_pair
#(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         meta_r <= '0;
         q_out <= '0;
      end
      else
      begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule
